/* File: hw/asr_ctrl.sv */
// host controller driving an asynchronous 512K x 8 static memory
// Behaviour
// - write ends at first rising select or write enable edge
// - address stable at least 60 ns before write end
// - address stable from write start until write end
// - write data stable 30 ns before write end, release after
// - controller never drives data while memory drives it
`timescale 1ns/1ps
module asr_ctrl
   import asr_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic WRITE,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   output logic READY,
   output logic [DATA_W-1:0] RDATA,
   output logic RDONE,
   output logic SRAM_CE_N,
   output logic SRAM_OE_N,
   output logic SRAM_WE_N,
   output logic [ADDR_W-1:0] SRAM_ADDR,
   input wire logic [DATA_W-1:0] SRAM_DATA_IN,
   output logic [DATA_W-1:0] SRAM_DATA_OUT,
   output logic SRAM_DATA_OE
);
   typedef struct packed {
      asr_state_t st;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic doe;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic [DATA_W-1:0] rdata;
      logic rdone;
   } asr_ctrl_t;

   asr_ctrl_t cur;
   asr_ctrl_t next_cur;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_value;
   logic tmr_done;

   asr_timer u_timer (
      .clock(CLOCK),
      .reset(RESET),
      .load(tmr_load),
      .load_value(tmr_value),
      .done(tmr_done)
   );

   assign READY = (cur.st == ASR_IDLE);

   always_comb
   begin
      next_cur = cur;
      tmr_load = 1'b0;
      tmr_value = CNT_RESET;
      // memory data is asynchronous to CLOCK
      next_cur.din_s1 = SRAM_DATA_IN;
      next_cur.din_s2 = cur.din_s1;
      next_cur.rdone = 1'b0;
      case (cur.st)
         ASR_IDLE:
         begin
            // deselected: memory stands by, other strobes kept high
            next_cur.ce_n = STROBE_IDLE;
            next_cur.oe_n = STROBE_IDLE;
            next_cur.we_n = STROBE_IDLE;
            if (REQ)
            begin
               next_cur.addr = ADDR;
               next_cur.ce_n = 1'b0;
               tmr_load = 1'b1;
               if (WRITE)
               begin
                  // output enable stays high, so the memory never drives
                  next_cur.we_n = 1'b0;
                  next_cur.dout = WDATA;
                  next_cur.doe = 1'b1;
                  tmr_value = WRITE_LOAD;
                  next_cur.st = ASR_WRITE;
               end
               else
               begin
                  next_cur.oe_n = 1'b0;
                  tmr_value = READ_LOAD;
                  next_cur.st = ASR_READ;
               end
            end
         end
         ASR_READ:
         begin
            if (tmr_done)
            begin
               // address held through the capture, so no hazard
               next_cur.rdata = cur.din_s2;
               next_cur.rdone = 1'b1;
               next_cur.ce_n = STROBE_IDLE;
               next_cur.oe_n = STROBE_IDLE;
               next_cur.st = ASR_HOLD;
            end
         end
         ASR_WRITE:
         begin
            if (tmr_done)
            begin
               // both rise together; data kept one more cycle as hold
               next_cur.we_n = STROBE_IDLE;
               next_cur.ce_n = STROBE_IDLE;
               next_cur.st = ASR_HOLD;
            end
         end
         ASR_HOLD:
         begin
            next_cur.doe = 1'b0;
            next_cur.st = ASR_IDLE;
         end
         default:
         begin
            next_cur.st = ASR_IDLE;
            next_cur.ce_n = STROBE_IDLE;
            next_cur.oe_n = STROBE_IDLE;
            next_cur.we_n = STROBE_IDLE;
            next_cur.doe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         cur.st <= ASR_IDLE;
         cur.ce_n <= STROBE_IDLE;
         cur.oe_n <= STROBE_IDLE;
         cur.we_n <= STROBE_IDLE;
         cur.addr <= ADDR_RESET;
         cur.dout <= DATA_RESET;
         cur.doe <= 1'b0;
         cur.din_s1 <= DATA_RESET;
         cur.din_s2 <= DATA_RESET;
         cur.rdata <= DATA_RESET;
         cur.rdone <= 1'b0;
      end
      else
         cur <= next_cur;
   end

   assign SRAM_CE_N = cur.ce_n;
   assign SRAM_OE_N = cur.oe_n;
   assign SRAM_WE_N = cur.we_n;
   assign SRAM_ADDR = cur.addr;
   assign SRAM_DATA_OUT = cur.dout;
   assign SRAM_DATA_OE = cur.doe;
   assign RDATA = cur.rdata;
   assign RDONE = cur.rdone;

   chk_no_contention: assert property (
      @(posedge CLOCK) disable iff (RESET)
      SRAM_DATA_OE |-> SRAM_OE_N)
      else $error("data driven while memory outputs enabled");

   chk_write_needs_select: assert property (
      @(posedge CLOCK) disable iff (RESET)
      !SRAM_WE_N |-> !SRAM_CE_N && SRAM_OE_N)
      else $error("write enable low without select");

   chk_we_pulse_width: assert property (
      @(posedge CLOCK) disable iff (RESET)
      $fell(SRAM_WE_N) |-> !SRAM_WE_N ##1 !SRAM_WE_N ##1 SRAM_WE_N)
      else $error("write enable pulse not two cycles");

   chk_write_addr_stable: assert property (
      @(posedge CLOCK) disable iff (RESET)
      !SRAM_WE_N ##1 1'b1 |-> $stable(SRAM_ADDR))
      else $error("address moved during write");

   chk_write_data_setup: assert property (
      @(posedge CLOCK) disable iff (RESET)
      $rose(SRAM_WE_N) |-> SRAM_DATA_OE && $stable(SRAM_DATA_OUT)
      ##1 !SRAM_DATA_OE)
      else $error("write data not held to write end");

   chk_write_end_edges: assert property (
      @(posedge CLOCK) disable iff (RESET)
      $rose(SRAM_WE_N) |-> $rose(SRAM_CE_N))
      else $error("write end edges not together");

   chk_read_strobes: assert property (
      @(posedge CLOCK) disable iff (RESET)
      !SRAM_OE_N |-> !SRAM_CE_N && SRAM_WE_N && !SRAM_DATA_OE)
      else $error("read strobes inconsistent");

   chk_read_latency: assert property (
      @(posedge CLOCK) disable iff (RESET)
      $fell(SRAM_OE_N) |-> !RDONE[*4] ##1 RDONE
      && RDATA == $past(SRAM_DATA_IN, 3))
      else $error("read answer not four cycles after strobe");

   chk_access_spacing: assert property (
      @(posedge CLOCK) disable iff (RESET)
      $rose(SRAM_CE_N) |-> SRAM_CE_N ##1 SRAM_CE_N)
      else $error("accesses too close together");

   chk_standby_quiet: assert property (
      @(posedge CLOCK) disable iff (RESET)
      SRAM_CE_N |-> SRAM_OE_N && SRAM_WE_N)
      else $error("strobes active while deselected");
endmodule // asr_ctrl

/* File: hw/asr_pkg.sv */
// constants and types shared by the static memory controller
package asr_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDRESS_ACCESS_TIME_NS = 70;
   localparam int SELECT_ACCESS_TIME_NS = 70;
   localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 35;
   localparam int WE_PULSE_MIN_NS = 55;
   localparam int ADDR_SETUP_TO_WRITE_END_NS = 60;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 30;
   localparam int ACCESS_SPACING_NS = 70;
   localparam int SYNC_STAGES = 2;

   // least time, rounded up to whole cycles, never below one
   function automatic int asr_min_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int asr_max3(input int a, input int b, input int c);
      int m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   localparam int READ_ACCESS_CYC = asr_max3(
      asr_min_cycles(ADDRESS_ACCESS_TIME_NS),
      asr_min_cycles(SELECT_ACCESS_TIME_NS),
      asr_min_cycles(OUTPUT_ENABLE_ACCESS_TIME_NS));
   localparam int READ_CYC = READ_ACCESS_CYC + SYNC_STAGES;
   localparam int WRITE_CYC = asr_max3(
      asr_min_cycles(WE_PULSE_MIN_NS),
      asr_min_cycles(ADDR_SETUP_TO_WRITE_END_NS),
      asr_min_cycles(DATA_SETUP_TO_WRITE_END_NS));
   localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_CYC - 1);
   localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYC - 1);

   localparam logic STROBE_IDLE = 1'h1;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

   typedef enum logic [1:0] {
      ASR_IDLE,
      ASR_READ,
      ASR_WRITE,
      ASR_HOLD
   } asr_state_t;
endpackage

/* File: hw/asr_timer.sv */
// down-counter that times strobe phases of the controller
`timescale 1ns/1ps
module asr_timer
   import asr_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   output logic done
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } asr_timer_t;

   asr_timer_t cur;
   asr_timer_t next_cur;

   always_comb
   begin
      next_cur = cur;
      if (load)
         next_cur.count = load_value;
      else if (cur.count != CNT_RESET)
         next_cur.count = cur.count - 4'h1;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         cur.count <= CNT_RESET;
      else
         cur <= next_cur;
   end

   assign done = (cur.count == CNT_RESET) && !load;
endmodule // asr_timer

/* File: tb/asr_mem_model.sv */
// behavioural static memory on the far side of the controller
`timescale 1ns/1ps
module asr_mem_model
   import asr_pkg::*;
#(parameter int ACC_NS = 70)
(
   input wire logic rst,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] pins,
   input wire logic host_oe,
   output logic [DATA_W-1:0] dout,
   output logic fault
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   realtime t_a, t_d, t_ws;
   realtime t_ce = -1000.0;
   wire logic drive = !ce_n && !oe_n && we_n;
   wire logic wr = !ce_n && !we_n;
   initial
   begin
      fault = 1'b0;
      dout = 8'h00;
   end
   // always the slowest legal answer; address read late, so no race
   always @(posedge drive)
   begin
      #ACC_NS;
      if (drive) dout = mem[addr];
   end
   // released pins show garbage, never the last byte
   always @(negedge drive) dout <= #10 ~dout;
   always @(addr) t_a = $realtime;
   always @(pins) t_d = $realtime;
   always @(posedge wr) t_ws = $realtime;
   always @(drive, host_oe)
      if (!rst && drive && host_oe) fault = 1'b1;
   always @(negedge ce_n)
   begin
      if (!rst && $realtime - t_ce < 70.0) fault = 1'b1;
      t_ce = $realtime;
   end
   always @(negedge wr)
   begin
      if (!rst)
      begin
         mem[addr] = pins;
         if ($realtime - t_a < 60.0) fault = 1'b1;
         if (t_a > t_ws) fault = 1'b1;
         if ($realtime - t_d < 30.0) fault = 1'b1;
         if ($realtime - t_ws < 55.0) fault = 1'b1;
      end
   end
endmodule // asr_mem_model

/* File: tb/async_sram_512k_x8_bench.sv */
// self-checking bench for the static memory controller
`timescale 1ns/1ps
module async_sram_512k_x8_bench;
   import asr_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic req = 1'b0;
   logic write = 1'b0;
   logic ready, rdone, ce_n, oe_n, we_n, doe, fault;
   logic [ADDR_W-1:0] addr = 19'h00000;
   logic [ADDR_W-1:0] maddr;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic [DATA_W-1:0] last = 8'h00;
   logic [DATA_W-1:0] rdata, dout, mdout, dpins;
   logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];
   int num_errors = 0;
   int check_count = 0;
   assign dpins = doe ? dout : mdout;
   asr_ctrl u_asr_ctrl (.CLOCK(clock), .RESET(reset), .REQ(req),
      .WRITE(write), .ADDR(addr), .WDATA(wdata), .READY(ready),
      .RDATA(rdata), .RDONE(rdone), .SRAM_CE_N(ce_n), .SRAM_OE_N(oe_n),
      .SRAM_WE_N(we_n), .SRAM_ADDR(maddr), .SRAM_DATA_IN(dpins),
      .SRAM_DATA_OUT(dout), .SRAM_DATA_OE(doe));
   asr_mem_model #(.ACC_NS(70)) u_asr_mem_model (.rst(reset),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(maddr),
      .pins(dpins), .host_oe(doe), .dout(mdout), .fault(fault));
   initial forever #20 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // poke: a second request while busy, which must be dropped
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic poke);
      logic [DATA_W-1:0] exp;
      exp = w ? last : shadow[a];
      @(posedge clock);
      req <= 1'b1;
      write <= w;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      req <= poke;
      write <= 1'b1;
      addr <= a ^ 19'h00001;
      wdata <= ~d;
      // k counts edges after the taking edge
      for (int k = 1; k <= 6; k++)
      begin
         @(posedge clock);
         if (k == 1) req <= 1'b0;
         @(negedge clock);
         chk(ready, k >= (w ? 3 : 5));
         chk(ce_n, k >= (w ? 2 : 4));
         chk(oe_n, w || k >= 4);
         chk(we_n, !w || k >= 2);
         chk(doe, w && k < 3);
         chk(maddr, a);
         chk(rdone, !w && k == 4);
         chk(rdata, (!w && k >= 4) ? exp : last);
         if (w && k < 3) chk(dout, d);
      end
      if (w)
         shadow[a] = d;
      else
         last = exp;
   endtask
   task t_reset;
      @(negedge clock);
      chk({ce_n, oe_n, we_n, doe, rdone, ready}, 6'h39);
      chk(maddr, 19'h00000);
      chk(rdata, 8'h00);
   endtask
   // both ends of the address range
   task t_range;
      access(1'b1, 19'h7FFFF, 8'hA5, 1'b0);
      access(1'b1, 19'h00000, 8'h5A, 1'b0);
      access(1'b0, 19'h7FFFF, 8'h00, 1'b0);
      access(1'b0, 19'h00000, 8'h00, 1'b0);
   endtask
   task t_refuse;
      access(1'b1, 19'h00010, 8'h3C, 1'b0);
      access(1'b1, 19'h00011, 8'h81, 1'b1);
      access(1'b0, 19'h00011, 8'h96, 1'b1);
      access(1'b0, 19'h00010, 8'h00, 1'b0);
   endtask
   initial
   begin
      #20000;
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_range();
      t_refuse();
      chk(fault, 1'b0);
      report_and_stop();
   end
endmodule // async_sram_512k_x8_bench
